//--- src/pieb_defines.svh
// Register map, field positions and bus codes of the interrupt flag bank
`ifndef PIEB_DEFINES_SVH
`define PIEB_DEFINES_SVH

`define PIEB_ADDR_W 8
`define PIEB_DATA_W 32
`define PIEB_STAT_W 16

// Register byte offsets
`define PIEB_OFS_ENA_A 8'h00
`define PIEB_OFS_ENA_B 8'h04
`define PIEB_OFS_FLG_A 8'h08
`define PIEB_OFS_FLG_B 8'h0C
`define PIEB_OFS_CORE 8'h10
`define PIEB_OFS_RX_DATA 8'h14
`define PIEB_OFS_TX_DATA 8'h18
`define PIEB_OFS_STATUS 8'h1C
`define PIEB_OFS_MASK 8'h20

// Implemented-bit masks; for flag bank A only the software-held bits, not the serial mirrors
`define PIEB_ENA_A_MASK 8'h7F
`define PIEB_ENA_B_MASK 8'hF0
`define PIEB_FLG_A_SW_MASK 8'h4F
`define PIEB_FLG_B_MASK 8'hF0
`define PIEB_CORE_MASK 8'hC0

// Field positions, bank A
`define PIEB_BIT_ADC 6
`define PIEB_BIT_RX 5
`define PIEB_BIT_TX 4
`define PIEB_BIT_SSP 3
`define PIEB_BIT_CC 2
`define PIEB_BIT_TB 1
`define PIEB_BIT_TA 0
// Field positions, bank B and core control
`define PIEB_BIT_OSF 7
`define PIEB_BIT_C2 6
`define PIEB_BIT_C1 5
`define PIEB_BIT_EE 4
`define PIEB_BIT_GIE 7
`define PIEB_BIT_PERIPHERAL_GROUP_ENABLE 6

// Bus responses
`define PIEB_RESP_OKAY 2'b00
`define PIEB_RESP_SLVERR 2'b10

`endif

//--- src/pieb_pkg.sv
// Types shared by the interrupt flag bank and its bus slave
`include "pieb_defines.svh"
package pieb_pkg;
	typedef enum logic [1:0] {
		PIEB_CC_CAPTURE = 2'b00,
		PIEB_CC_COMPARE = 2'b01,
		PIEB_CC_PWM = 2'b10,
		PIEB_CC_OFF = 2'b11
	} pieb_cc_mode_t;

	typedef struct packed {
		logic aw_full;
		logic [`PIEB_ADDR_W-1:0] awaddr;
		logic w_full;
		logic [`PIEB_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [`PIEB_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} pieb_slv_state_t;

	typedef struct packed {
		logic [7:0] ena_a;
		logic [7:0] ena_b;
		logic [7:0] flg_a;
		logic [7:0] flg_b;
		logic [7:0] core;
		logic [7:0] tx_data;
		logic [`PIEB_STAT_W-1:0] status;
		logic [`PIEB_STAT_W-1:0] mask;
		logic [1:0] cmp_prev;
		logic primed;
		logic rx_read;
		logic tx_write;
		logic req;
		logic irq;
	} pieb_state_t;
endpackage

//--- src/pieb_axil_slave.sv
// AXI4-Lite slave front end: one read under way at a time; the next write is taken and held while a write response waits
`timescale 1ns/1ps
`default_nettype none
`include "pieb_defines.svh"
module pieb_axil_slave (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Write address and data
	input wire logic [`PIEB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`PIEB_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [`PIEB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`PIEB_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output logic wr_en,
	output logic [`PIEB_ADDR_W-1:0] wr_addr,
	output logic [`PIEB_DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_en,
	output logic [`PIEB_ADDR_W-1:0] rd_addr,
	input wire logic [`PIEB_DATA_W-1:0] rd_data,
	input wire logic rd_err
);
	import pieb_pkg::*;

	pieb_slv_state_t s_reg;
	pieb_slv_state_t s_next;

	// Write strobes come from held channel contents; read strobes and address come from the live read address channel
	assign wr_en = s_reg.aw_full & s_reg.w_full & ~s_reg.bvalid;
	assign wr_addr = s_reg.awaddr;
	assign wr_data = s_reg.wdata;
	assign wr_strb = s_reg.wstrb;
	assign rd_en = s_axi_arvalid & s_reg.arready;
	assign rd_addr = s_axi_araddr;

	// Address and data may arrive in either order; each is held until both are in
	always_comb begin
		s_next = s_reg;
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_full = 1'b1;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_full = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (wr_en) begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = wr_err ? `PIEB_RESP_SLVERR : `PIEB_RESP_OKAY;
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		// Read data is sampled at the address edge so side effects act once
		if (rd_en) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_data;
			s_next.rresp = rd_err ? `PIEB_RESP_SLVERR : `PIEB_RESP_OKAY;
		end
		s_next.awready = ~s_next.aw_full;
		s_next.wready = ~s_next.w_full;
		s_next.arready = ~s_next.rvalid;
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Bus outputs straight from the state
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
endmodule
`default_nettype wire

//--- src/pieb_top.sv
// Peripheral interrupt enable and flag bank with AXI4-Lite register access
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pieb_defines.svh"
module pieb_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// AXI4-Lite write address and data
	input wire logic [`PIEB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`PIEB_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [`PIEB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`PIEB_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral event strobes
	input wire logic adc_done_evt,
	input wire logic sync_serial_done_evt,
	input wire logic capcomp_capture_evt,
	input wire logic capcomp_compare_evt,
	input wire pieb_pkg::pieb_cc_mode_t capcomp_mode,
	input wire logic timer_b_match_evt,
	input wire logic timer_a_overflow_evt,
	input wire logic osc_fail_evt,
	input wire logic eeprom_write_done_evt,
	// Peripheral levels
	input wire logic comparator_one_output,
	input wire logic comparator_two_output,
	input wire logic serial_rx_full,
	input wire logic serial_tx_empty,
	input wire logic [7:0] serial_rx_data,
	// Serial data register side effects
	output logic serial_rx_data_read,
	output logic serial_tx_data_write,
	output logic [7:0] serial_tx_data,
	// Core request and bus interrupt
	output logic periph_irq_request,
	output logic bus_irq
);
	import pieb_pkg::*;

	pieb_state_t s_reg;
	pieb_state_t s_next;

	logic wr_en;
	logic [`PIEB_ADDR_W-1:0] wr_addr;
	logic [`PIEB_DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [`PIEB_ADDR_W-1:0] rd_addr;
	logic [`PIEB_DATA_W-1:0] rd_data;
	logic rd_err;

	// Bus front end
	pieb_axil_slave u_slave (
		.core_clk(core_clk),
		.rstn(rstn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Address decode for both directions
	function automatic logic is_mapped(input logic [`PIEB_ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			`PIEB_OFS_ENA_A: hit = 1'b1;
			`PIEB_OFS_ENA_B: hit = 1'b1;
			`PIEB_OFS_FLG_A: hit = 1'b1;
			`PIEB_OFS_FLG_B: hit = 1'b1;
			`PIEB_OFS_CORE: hit = 1'b1;
			`PIEB_OFS_RX_DATA: hit = 1'b1;
			`PIEB_OFS_TX_DATA: hit = 1'b1;
			`PIEB_OFS_STATUS: hit = 1'b1;
			`PIEB_OFS_MASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	assign wr_err = ~is_mapped(wr_addr);
	assign rd_err = ~is_mapped(rd_addr);

	// Write strobes per register; only byte lane 0 carries data, except lane 1 for the upper mask byte
	logic wr_lane0;
	logic wr_ena_a;
	logic wr_ena_b;
	logic wr_flg_a;
	logic wr_flg_b;
	logic wr_core;
	logic wr_tx;
	logic wr_mask_lo;
	logic wr_mask_hi;
	logic rd_status;
	logic rd_rx;

	assign wr_lane0 = wr_en & wr_strb[0];
	assign wr_ena_a = wr_lane0 & (wr_addr == `PIEB_OFS_ENA_A);
	assign wr_ena_b = wr_lane0 & (wr_addr == `PIEB_OFS_ENA_B);
	assign wr_flg_a = wr_lane0 & (wr_addr == `PIEB_OFS_FLG_A);
	assign wr_flg_b = wr_lane0 & (wr_addr == `PIEB_OFS_FLG_B);
	assign wr_core = wr_lane0 & (wr_addr == `PIEB_OFS_CORE);
	assign wr_tx = wr_lane0 & (wr_addr == `PIEB_OFS_TX_DATA);
	assign wr_mask_lo = wr_lane0 & (wr_addr == `PIEB_OFS_MASK);
	assign wr_mask_hi = wr_en & wr_strb[1] & (wr_addr == `PIEB_OFS_MASK);
	assign rd_status = rd_en & (rd_addr == `PIEB_OFS_STATUS);
	assign rd_rx = rd_en & (rd_addr == `PIEB_OFS_RX_DATA);

	// Hardware set conditions, banks A and B
	logic [7:0] set_a;
	logic [7:0] set_b;
	logic cc_hit;
	logic [1:0] cmp_now;
	logic [1:0] cmp_chg;

	// Capture or compare source picked by mode; PWM mode never flags
	always_comb begin
		case (capcomp_mode)
			PIEB_CC_CAPTURE: cc_hit = capcomp_capture_evt;
			PIEB_CC_COMPARE: cc_hit = capcomp_compare_evt;
			PIEB_CC_PWM: cc_hit = 1'b0;
			default: cc_hit = 1'b0;
		endcase
	end

	// Comparator edges; the first cycle after reset only learns the level
	assign cmp_now = {comparator_two_output, comparator_one_output};
	assign cmp_chg = s_reg.primed ? (cmp_now ^ s_reg.cmp_prev) : 2'b00;

	// Event vectors, independent of any enable bit
	always_comb begin
		set_a = 8'h00;
		set_a[`PIEB_BIT_ADC] = adc_done_evt;
		set_a[`PIEB_BIT_SSP] = sync_serial_done_evt;
		set_a[`PIEB_BIT_CC] = cc_hit;
		set_a[`PIEB_BIT_TB] = timer_b_match_evt;
		set_a[`PIEB_BIT_TA] = timer_a_overflow_evt;
		set_b = 8'h00;
		set_b[`PIEB_BIT_OSF] = osc_fail_evt;
		set_b[`PIEB_BIT_C2] = cmp_chg[1];
		set_b[`PIEB_BIT_C1] = cmp_chg[0];
		set_b[`PIEB_BIT_EE] = eeprom_write_done_evt;
	end

	// Status events: every hardware set event, plus the serial mirrors rising
	logic [7:0] rise_a;
	logic [`PIEB_STAT_W-1:0] stat_set;
	logic [7:0] any_a;
	logic [7:0] any_b;

	// Next-state logic of the whole bank
	always_comb begin
		s_next = s_reg;
		s_next.cmp_prev = cmp_now;
		s_next.primed = 1'b1;
		s_next.rx_read = rd_rx;
		s_next.tx_write = wr_tx;
		// Enable registers keep only their implemented bits
		if (wr_ena_a) begin
			s_next.ena_a = wr_data[7:0] & `PIEB_ENA_A_MASK;
		end
		if (wr_ena_b) begin
			s_next.ena_b = wr_data[7:0] & `PIEB_ENA_B_MASK;
		end
		if (wr_core) begin
			s_next.core = wr_data[7:0] & `PIEB_CORE_MASK;
		end
		if (wr_tx) begin
			s_next.tx_data = wr_data[7:0];
		end
		// Software-held flags: written value, then events on top
		if (wr_flg_a) begin
			s_next.flg_a = wr_data[7:0] & `PIEB_FLG_A_SW_MASK;
		end else begin
			s_next.flg_a = s_reg.flg_a & `PIEB_FLG_A_SW_MASK;
		end
		s_next.flg_a = s_next.flg_a | set_a;
		// Serial mirrors; forced low for the read or write and the cycle after,
		// giving the serial unit time to drop its level
		s_next.flg_a[`PIEB_BIT_RX] = serial_rx_full & ~rd_rx & ~s_reg.rx_read;
		s_next.flg_a[`PIEB_BIT_TX] = serial_tx_empty & ~wr_tx & ~s_reg.tx_write;
		if (wr_flg_b) begin
			s_next.flg_b = wr_data[7:0] & `PIEB_FLG_B_MASK;
		end else begin
			s_next.flg_b = s_reg.flg_b;
		end
		s_next.flg_b = s_next.flg_b | set_b;
		// Sticky status: read clears, an event in the same cycle stays
		rise_a = s_next.flg_a & ~s_reg.flg_a;
		stat_set = {set_b, set_a | (rise_a & ~`PIEB_FLG_A_SW_MASK)};
		s_next.status = (rd_status ? '0 : s_reg.status) | stat_set;
		if (wr_mask_lo) begin
			s_next.mask[7:0] = wr_data[7:0];
		end
		if (wr_mask_hi) begin
			s_next.mask[15:8] = wr_data[15:8];
		end
		s_next.irq = |(s_next.status & s_next.mask);
		// Core request gated by group and global enables
		any_a = s_next.flg_a & s_next.ena_a;
		any_b = s_next.flg_b & s_next.ena_b;
		s_next.req = s_next.core[`PIEB_BIT_GIE] & s_next.core[`PIEB_BIT_PERIPHERAL_GROUP_ENABLE]
			& (|any_a | |any_b);
	end

	// Read mux; unimplemented positions are zero in every stored value
	always_comb begin
		rd_data = '0;
		case (rd_addr)
			`PIEB_OFS_ENA_A: rd_data[7:0] = s_reg.ena_a;
			`PIEB_OFS_ENA_B: rd_data[7:0] = s_reg.ena_b;
			`PIEB_OFS_FLG_A: rd_data[7:0] = s_reg.flg_a;
			`PIEB_OFS_FLG_B: rd_data[7:0] = s_reg.flg_b;
			`PIEB_OFS_CORE: rd_data[7:0] = s_reg.core;
			`PIEB_OFS_RX_DATA: rd_data[7:0] = serial_rx_data;
			`PIEB_OFS_TX_DATA: rd_data[7:0] = s_reg.tx_data;
			`PIEB_OFS_STATUS: rd_data[`PIEB_STAT_W-1:0] = s_reg.status;
			`PIEB_OFS_MASK: rd_data[`PIEB_STAT_W-1:0] = s_reg.mask;
			default: rd_data = '0;
		endcase
	end

	// State register; every field resets to zero
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state
	assign serial_rx_data_read = s_reg.rx_read;
	assign serial_tx_data_write = s_reg.tx_write;
	assign serial_tx_data = s_reg.tx_data;
	assign periph_irq_request = s_reg.req;
	assign bus_irq = s_reg.irq;
endmodule
`default_nettype wire

//--- sim/pieb_asserts.sv
// Port-level checks of the flag bank register bus and strobes
`timescale 1ns/1ps
`default_nettype none
`include "pieb_defines.svh"
module pieb_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Read channels
	input wire logic [`PIEB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [`PIEB_DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Write response
	input wire logic s_axi_bvalid,
	// Side effects and requests
	input wire logic serial_rx_data_read,
	input wire logic serial_tx_data_write,
	input wire logic periph_irq_request,
	input wire logic bus_irq
);
	logic [`PIEB_ADDR_W-1:0] ra_reg;
	// Address of the read in flight, so data checks know the register
	always_ff @(posedge core_clk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ra_reg <= s_axi_araddr;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rx_pick;
		s_ar_take ##0 s_axi_araddr == `PIEB_OFS_RX_DATA;
	endsequence
	a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	a_bad_addr: assert property (s_ar_take ##0 s_axi_araddr > 8'h20 |=>
		s_axi_rresp == `PIEB_RESP_SLVERR)
		else $error("unmapped read not refused");
	a_rx_read_pulse: assert property (s_rx_pick |=> serial_rx_data_read ##1 !serial_rx_data_read)
		else $error("receive read strobe wrong");
	a_tx_write_pulse: assert property (serial_tx_data_write |->
		(s_axi_bvalid || $past(s_axi_bvalid)) ##1 !serial_tx_data_write)
		else $error("transmit write strobe wrong");
	a_upper_zero: assert property (s_axi_rvalid && ra_reg <= 8'h18 |->
		s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_top_bit_zero: assert property (s_axi_rvalid && ra_reg inside {8'h00, 8'h08} |->
		!s_axi_rdata[7])
		else $error("bit 7 not zero");
	a_low_bits_zero: assert property (s_axi_rvalid && ra_reg inside {8'h04, 8'h0C} |->
		s_axi_rdata[3:0] == 4'h0)
		else $error("bits 3 to 0 not zero");
	// Reset must leave the core request quiet, so no disable here
	a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
		!rstn |=> !periph_irq_request && !bus_irq)
		else $error("request after reset");
endmodule
bind pieb_top pieb_asserts u_pieb_asserts (.core_clk, .rstn, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
	.serial_rx_data_read, .serial_tx_data_write, .periph_irq_request, .bus_irq);
`default_nettype wire

//--- sim/pieb_periph_model.sv
// Serial buffer model standing beside the flag bank
`timescale 1ns/1ps
`default_nettype none
module pieb_periph_model #(
	parameter int TX_CYCLES = 20
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Bench commands
	input wire logic rx_push,
	input wire logic [7:0] rx_byte,
	// Strobes from the flag bank
	input wire logic serial_rx_data_read,
	input wire logic serial_tx_data_write,
	// Buffer levels
	output logic serial_rx_full,
	output logic serial_tx_empty,
	output logic [7:0] serial_rx_data
);
	logic [7:0] hold_reg;
	int tx_cnt;
	// Full drops at the edge that sees the read strobe
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			serial_rx_full <= 1'b0;
			hold_reg <= 8'h00;
		end else if (serial_rx_data_read) begin
			serial_rx_full <= 1'b0;
		end else if (rx_push) begin
			serial_rx_full <= 1'b1;
			hold_reg <= rx_byte;
		end
	end
	// Empty slot shows inverted junk, never a stale byte
	assign serial_rx_data = serial_rx_full ? hold_reg : ~hold_reg;
	// Transmit slot empties again after a fixed shift time
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tx_cnt <= 0;
		end else if (serial_tx_data_write) begin
			tx_cnt <= TX_CYCLES;
		end else if (tx_cnt > 0) begin
			tx_cnt <= tx_cnt - 1;
		end
	end
	assign serial_tx_empty = (tx_cnt == 0);
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ps
`default_nettype none
`include "pieb_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import pieb_pkg::*;
	logic core_clk, rstn, rx_push, comparator_one_output, comparator_two_output;
	logic [7:0] s_axi_awaddr, s_axi_araddr, ev, rx_byte, serial_rx_data, serial_tx_data;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, serial_rx_full;
	logic serial_tx_empty, serial_rx_data_read, serial_tx_data_write, periph_irq_request, bus_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] got;
	pieb_cc_mode_t capcomp_mode;
	int bad_count, n_tests;
	logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
	logic [7:0] wmax [4] = '{8'h7F, 8'hF0, 8'h5F, 8'hF0};
	logic [15:0] eexp [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0040,
		16'h1000, 16'h8000, 16'h2000, 16'h4000};
	// Event strobes fan out from one vector
	wire logic timer_a_overflow_evt = ev[0];
	wire logic timer_b_match_evt = ev[1];
	wire logic capcomp_capture_evt = ev[2];
	wire logic sync_serial_done_evt = ev[3];
	wire logic adc_done_evt = ev[4];
	wire logic eeprom_write_done_evt = ev[5];
	wire logic osc_fail_evt = ev[6];
	wire logic capcomp_compare_evt = ev[7];
	pieb_top u_pieb_top (.*);
	pieb_periph_model #(.TX_CYCLES(20)) u_pieb_periph_model (.core_clk(core_clk), .rstn(rstn),
		.rx_push(rx_push), .rx_byte(rx_byte), .serial_rx_data_read(serial_rx_data_read),
		.serial_tx_data_write(serial_tx_data_write), .serial_rx_full(serial_rx_full),
		.serial_tx_empty(serial_tx_empty), .serial_rx_data(serial_rx_data));
	// Bus write; a stall delays bready so the response must wait
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input int st = 0,
		input logic [3:0] sb = 4'hF);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= sb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		fork
			begin do @(posedge core_clk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
			begin do @(posedge core_clk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
		join
		repeat (st) @(posedge core_clk);
		s_axi_bready <= 1'b1;
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Bus read; result lands in d and rsp
	task automatic rd(input logic [7:0] a, input int st = 0);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (st) @(posedge core_clk);
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// One-cycle event strobe, returns once the flag update has landed
	task automatic pulse(input logic [7:0] m);
		@(posedge core_clk);
		ev <= m;
		@(posedge core_clk);
		ev <= 8'h00;
		@(posedge core_clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Watchdog: the sequence needs only a few hundred cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		end_of_test;
	end
	initial begin
		{rstn, rx_push, rx_byte, ev, comparator_one_output, comparator_two_output} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		capcomp_mode = PIEB_CC_CAPTURE;
		bad_count = 0;
		n_tests = 0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		// Reset values, unimplemented bits, write-zero clear
		for (int i = 0; i < 4; i++) begin
			rd(ofs[i]);
			`CHK(d, {24'h00_0000, i == 2 ? 8'h10 : 8'h00})
			wr(ofs[i], 32'hFFFF_FFFF, i);
			rd(ofs[i], i);
			`CHK(d, {24'h00_0000, wmax[i]})
			wr(ofs[i], 32'h0000_0000);
			rd(ofs[i]);
			`CHK(d, {24'h00_0000, i == 2 ? 8'h10 : 8'h00})
		end
		// Write with no byte lane enabled is ignored
		wr(`PIEB_OFS_ENA_A, 32'h0000_00FF, 0, 4'h0);
		rd(`PIEB_OFS_ENA_A);
		`CHK(d, 32'h0000_0000)
		wr(8'h40, 32'h0000_0001);
		`CHK(rsp, `PIEB_RESP_SLVERR)
		rd(8'h40);
		`CHK(rsp, `PIEB_RESP_SLVERR)
		// Status, mask and the bus interrupt
		rd(`PIEB_OFS_STATUS);
		wr(`PIEB_OFS_MASK, 32'h0000_0000, 0, 4'h3);
		pulse(8'h01);
		`CHK(bus_irq, 1'b0)
		rd(`PIEB_OFS_STATUS);
		`CHK(d, 32'h0000_0001)
		rd(`PIEB_OFS_STATUS);
		`CHK(d, 32'h0000_0000)
		wr(`PIEB_OFS_MASK, 32'h0000_FFFF, 0, 4'h3);
		pulse(8'h10);
		`CHK(bus_irq, 1'b1)
		rd(`PIEB_OFS_STATUS);
		`CHK(d, 32'h0000_0040)
		repeat (2) @(posedge core_clk);
		`CHK(bus_irq, 1'b0)
		// Flags cleared before enables; transmit enable left off
		wr(`PIEB_OFS_FLG_A, 32'h0000_0000);
		wr(`PIEB_OFS_FLG_B, 32'h0000_0000);
		wr(`PIEB_OFS_ENA_A, 32'h0000_006F);
		wr(`PIEB_OFS_ENA_B, 32'h0000_00F0);
		wr(`PIEB_OFS_CORE, 32'h0000_0080);
		// Every event source but the compare strobe, gated by the group enable
		for (int i = 0; i < 9; i++) begin
			if (i < 7) begin
				pulse(8'h01 << i);
			end else begin
				@(posedge core_clk);
				if (i == 7) comparator_one_output <= ~comparator_one_output;
				else comparator_two_output <= ~comparator_two_output;
				repeat (2) @(posedge core_clk);
			end
			rd(`PIEB_OFS_FLG_A);
			got[7:0] = d[7:0];
			rd(`PIEB_OFS_FLG_B);
			got[15:8] = d[7:0];
			`CHK(got, eexp[i] | 16'h0010)
			`CHK(periph_irq_request, 1'b0)
			wr(`PIEB_OFS_CORE, 32'h0000_00C0);
			`CHK(periph_irq_request, 1'b1)
			wr(`PIEB_OFS_FLG_A, 32'h0000_0000);
			wr(`PIEB_OFS_FLG_B, 32'h0000_0000);
			`CHK(periph_irq_request, 1'b0)
			wr(`PIEB_OFS_CORE, 32'h0000_0080);
		end
		// Capture/compare flag in each mode
		for (int m = 0; m < 4; m++) begin
			@(posedge core_clk) capcomp_mode <= pieb_cc_mode_t'(2'(m));
			pulse(8'h84);
			rd(`PIEB_OFS_FLG_A);
			`CHK(d[2], m < 2)
			wr(`PIEB_OFS_FLG_A, 32'h0000_0000);
		end
		// Event held across a clearing write: the set wins
		@(posedge core_clk);
		ev <= 8'h01;
		wr(`PIEB_OFS_FLG_A, 32'h0000_0000);
		ev <= 8'h00;
		rd(`PIEB_OFS_FLG_A);
		`CHK(d[0], 1'b1)
		wr(`PIEB_OFS_FLG_A, 32'h0000_0000);
		rd(`PIEB_OFS_FLG_A);
		`CHK(d[0], 1'b0)
		// Receive and transmit mirrors
		@(posedge core_clk);
		rx_byte <= 8'hA5;
		rx_push <= 1'b1;
		@(posedge core_clk);
		rx_push <= 1'b0;
		rd(`PIEB_OFS_FLG_A);
		`CHK(d[5], 1'b1)
		rd(`PIEB_OFS_RX_DATA);
		`CHK(d, 32'h0000_00A5)
		rd(`PIEB_OFS_FLG_A);
		`CHK(d[5], 1'b0)
		wr(`PIEB_OFS_TX_DATA, 32'h0000_003C);
		`CHK(serial_tx_data, 8'h3C)
		rd(`PIEB_OFS_FLG_A);
		`CHK(d[4], 1'b0)
		repeat (30) @(posedge core_clk);
		rd(`PIEB_OFS_FLG_A);
		`CHK(d[4], 1'b1)
		end_of_test;
	end
endmodule
`default_nettype wire
